// *** pfs_pad_mux.sv ***
// Pad multiplexing, pull-up control and test-port pad logic
//
// Functional notes
// R1 - Pad 49 resets to GPIO input, pull-up on
// R2 - Port D enable bit 1 hands pad 49 over
// R3 - Global select bit 5 picks chip select or CAN
// R4 - Port D pull-up bit 1 clear drops pull-up
// R5 - Chip select idles tri-stated or driven per control
// R6 - Software should set idle drive control to one
// R7 - CAN receive use keeps internal pull-up
// R8 - Transmit pads: reset disabled, pull-up, then serial
// R9 - Second receive pad defaults serial, pull-up in reset
// R10 - Port E pull-up bits 0,1 drop serial-zero pull-ups
// R11 - Port D pull-up bits 6,7 drop serial-one pull-ups
// R12 - Each GPIO pad individually input or output
// R13 - Test clock input carries a pull-down
// R14 - Mode select sampled on rising test clock
// R15 - Test data in sampled on rising test clock
// R16 - Test-port disable bit removes mode/data pull-ups
// R17 - Test data out driven in shifts, falling edge
// R18 - Without peripheral enable, GPIO alone drives pad
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module pfs_pad_mux
  import pfs_pkg::*;
(
  input logic clk,
  input logic rst_n,
  // Configuration write and read-back
  input pfs_wr_t wr,
  input pfs_reg_t rd_sel,
  output logic [`PFS_W-1:0] rd_data,
  // Port D line one, pad 49
  input logic d1_in,
  output pfs_pad_t d1_pad,
  // Serial pads
  input logic e0_in,
  output pfs_pad_t e0_pad,
  input logic e1_in,
  output pfs_pad_t e1_pad,
  input logic d6_in,
  output pfs_pad_t d6_pad,
  input logic d7_in,
  output pfs_pad_t d7_pad,
  // External memory interface side
  input logic memory_chip_select_three_n,
  input logic ext_bus_active,
  input logic idle_bus_drive_control,
  // Peripheral side
  output logic can_receive_input,
  input logic serial_zero_transmit,
  output logic serial_zero_receive,
  input logic serial_one_transmit,
  output logic serial_one_receive,
  // Test port
  input logic tck,
  input logic tms,
  input logic tdi,
  output logic tck_pd,
  output logic tms_pu,
  output logic tdi_pu,
  input logic tdo_src,
  output pfs_pad_t tdo_pad,
  output logic tdi_bit,
  output logic tdi_strobe,
  output pfs_tap_t tap_state
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Peripheral enable clear means GPIO owns direction and data
  function automatic pfs_pad_t pad_mux(input logic per,
                                       input logic dir,
                                       input logic dat,
                                       input logic pur,
                                       input logic p_o,
                                       input logic p_oe);
    pfs_pad_t p;
    p.o = per ? p_o : dat; // [R18]
    p.oe = per ? p_oe : dir; // [R12]
    // Pull-up only on a pad that is not driving
    p.pu = pur & ~p.oe;
    return p;
  endfunction

  function automatic logic is_shift(input pfs_tap_t s);
    return (s == pfs_tap_shift_ir) || (s == pfs_tap_shift_dr);
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [`PFS_W-1:0] per_d_r, per_d_nxt;
  logic [`PFS_W-1:0] per_e_r, per_e_nxt;
  logic [`PFS_W-1:0] gps_r, gps_nxt;
  logic [`PFS_W-1:0] pur_d_r, pur_d_nxt;
  logic [`PFS_W-1:0] pur_e_r, pur_e_nxt;
  logic [`PFS_W-1:0] pudr_r, pudr_nxt;
  logic [`PFS_W-1:0] dir_d_r, dir_d_nxt;
  logic [`PFS_W-1:0] dir_e_r, dir_e_nxt;
  logic [`PFS_W-1:0] dat_d_r, dat_d_nxt;
  logic [`PFS_W-1:0] dat_e_r, dat_e_nxt;

  always_comb begin
    per_d_nxt = per_d_r;
    per_e_nxt = per_e_r;
    gps_nxt = gps_r;
    pur_d_nxt = pur_d_r;
    pur_e_nxt = pur_e_r;
    pudr_nxt = pudr_r;
    dir_d_nxt = dir_d_r;
    dir_e_nxt = dir_e_r;
    dat_d_nxt = dat_d_r;
    dat_e_nxt = dat_e_r;
    if (wr.we) begin
      case (wr.sel)
        pfs_port_d_peripheral_enable: per_d_nxt = wr.data;
        pfs_port_e_peripheral_enable: per_e_nxt = wr.data;
        pfs_global_peripheral_select: gps_nxt = wr.data;
        pfs_port_d_pullup_enable: pur_d_nxt = wr.data;
        pfs_port_e_pullup_enable: pur_e_nxt = wr.data;
        pfs_pullup_disable_register: pudr_nxt = wr.data;
        pfs_port_d_direction: dir_d_nxt = wr.data;
        pfs_port_e_direction: dir_e_nxt = wr.data;
        pfs_port_d_data: dat_d_nxt = wr.data;
        pfs_port_e_data: dat_e_nxt = wr.data;
        // Pin views are read-only
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_d_r <= `PFS_RST_PER_D; // [R1] [R8] [R9]
      per_e_r <= `PFS_RST_PER_E; // [R8]
      gps_r <= `PFS_RST_GPS;
      pur_d_r <= `PFS_RST_PUR;
      pur_e_r <= `PFS_RST_PUR;
      pudr_r <= `PFS_RST_PUDR;
      dir_d_r <= `PFS_RST_DIR; // [R1]
      dir_e_r <= `PFS_RST_DIR;
      dat_d_r <= `PFS_RST_DATA;
      dat_e_r <= `PFS_RST_DATA;
    end else begin
      per_d_r <= per_d_nxt;
      per_e_r <= per_e_nxt;
      gps_r <= gps_nxt;
      pur_d_r <= pur_d_nxt;
      pur_e_r <= pur_e_nxt;
      pudr_r <= pudr_nxt;
      dir_d_r <= dir_d_nxt;
      dir_e_r <= dir_e_nxt;
      dat_d_r <= dat_d_nxt;
      dat_e_r <= dat_e_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pad multiplexing
  // ----------------------------------------------------------------
  pfs_pad_t d1_nxt, e0_nxt, e1_nxt, d6_nxt, d7_nxt;
  logic can_nxt, serial_port_zero_rx_nxt, serial_port_one_rx_nxt;
  logic d1_can, d1_cs_oe;
  logic [`PFS_W-1:0] pins_d, pins_e;

  always_comb begin
    d1_can = gps_r[`PFS_BIT_GPS_D_LINE_ONE]; // [R3]
    // Idle bus either floats the select or keeps driving it
    d1_cs_oe = ext_bus_active | idle_bus_drive_control; // [R5] [R6]
    d1_nxt = pad_mux(per_d_r[`PFS_BIT_D_LINE_ONE], // [R2]
                     dir_d_r[`PFS_BIT_D_LINE_ONE],
                     dat_d_r[`PFS_BIT_D_LINE_ONE],
                     pur_d_r[`PFS_BIT_D_LINE_ONE], // [R4] [R7]
                     d1_can | memory_chip_select_three_n,
                     ~d1_can & d1_cs_oe); // [R5]
    e0_nxt = pad_mux(per_e_r[`PFS_BIT_E_LINE_ZERO], // [R8]
                     dir_e_r[`PFS_BIT_E_LINE_ZERO],
                     dat_e_r[`PFS_BIT_E_LINE_ZERO],
                     pur_e_r[`PFS_BIT_E_LINE_ZERO], // [R10]
                     serial_zero_transmit, 1'b1);
    e1_nxt = pad_mux(per_e_r[`PFS_BIT_E_LINE_ONE],
                     dir_e_r[`PFS_BIT_E_LINE_ONE],
                     dat_e_r[`PFS_BIT_E_LINE_ONE],
                     pur_e_r[`PFS_BIT_E_LINE_ONE], // [R10]
                     1'b1, 1'b0);
    d6_nxt = pad_mux(per_d_r[`PFS_BIT_D_LINE_SIX], // [R8]
                     dir_d_r[`PFS_BIT_D_LINE_SIX],
                     dat_d_r[`PFS_BIT_D_LINE_SIX],
                     pur_d_r[`PFS_BIT_D_LINE_SIX], // [R11]
                     serial_one_transmit, 1'b1);
    d7_nxt = pad_mux(per_d_r[`PFS_BIT_D_LINE_SEVEN], // [R9]
                     dir_d_r[`PFS_BIT_D_LINE_SEVEN],
                     dat_d_r[`PFS_BIT_D_LINE_SEVEN],
                     pur_d_r[`PFS_BIT_D_LINE_SEVEN], // [R11]
                     1'b1, 1'b0);
    // Unrouted receivers idle high, the recessive level
    can_nxt = 1'b1;
    if (per_d_r[`PFS_BIT_D_LINE_ONE] && d1_can) begin
      can_nxt = d1_in; // [R3]
    end
    serial_port_zero_rx_nxt = per_e_r[`PFS_BIT_E_LINE_ONE] ? e1_in : 1'b1;
    serial_port_one_rx_nxt = per_d_r[`PFS_BIT_D_LINE_SEVEN] ? d7_in : 1'b1;
    pins_d = `PFS_ZERO;
    pins_d[`PFS_BIT_D_LINE_ONE] = d1_in;
    pins_d[`PFS_BIT_D_LINE_SIX] = d6_in;
    pins_d[`PFS_BIT_D_LINE_SEVEN] = d7_in;
    pins_e = `PFS_ZERO;
    pins_e[`PFS_BIT_E_LINE_ZERO] = e0_in;
    pins_e[`PFS_BIT_E_LINE_ONE] = e1_in;
  end

  // Registered pads cost one cycle but keep glitches off the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      d1_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1}; // [R1]
      e0_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1}; // [R8]
      e1_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1};
      d6_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1}; // [R8]
      d7_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1}; // [R9]
      can_receive_input <= 1'b1;
      serial_zero_receive <= 1'b1;
      serial_one_receive <= 1'b1;
    end else begin
      d1_pad <= d1_nxt;
      e0_pad <= e0_nxt;
      e1_pad <= e1_nxt;
      d6_pad <= d6_nxt;
      d7_pad <= d7_nxt;
      can_receive_input <= can_nxt;
      serial_zero_receive <= serial_port_zero_rx_nxt;
      serial_one_receive <= serial_port_one_rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  logic [`PFS_W-1:0] rd_nxt;

  always_comb begin
    case (rd_sel)
      pfs_port_d_peripheral_enable: rd_nxt = per_d_r;
      pfs_port_e_peripheral_enable: rd_nxt = per_e_r;
      pfs_global_peripheral_select: rd_nxt = gps_r;
      pfs_port_d_pullup_enable: rd_nxt = pur_d_r;
      pfs_port_e_pullup_enable: rd_nxt = pur_e_r;
      pfs_pullup_disable_register: rd_nxt = pudr_r;
      pfs_port_d_direction: rd_nxt = dir_d_r;
      pfs_port_e_direction: rd_nxt = dir_e_r;
      pfs_port_d_data: rd_nxt = dat_d_r;
      pfs_port_e_data: rd_nxt = dat_e_r;
      pfs_port_d_pins: rd_nxt = pins_d;
      pfs_port_e_pins: rd_nxt = pins_e;
      default: rd_nxt = `PFS_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= `PFS_ZERO;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Test port
  // ----------------------------------------------------------------
  // Test clock is sampled, so it must run well below clk
  assign tck_pd = 1'b1; // [R13]
  assign tms_pu = ~pudr_r[`PFS_BIT_PUD_TEST]; // [R16]
  assign tdi_pu = ~pudr_r[`PFS_BIT_PUD_TEST]; // [R16]

  logic tck_q_r, tck_q_nxt;
  logic tck_rise, tck_fall;
  pfs_tap_t tap_r, tap_nxt;
  logic tdi_bit_nxt, tdi_strobe_nxt;
  pfs_pad_t tdo_nxt;

  always_comb begin
    tck_q_nxt = tck;
    tck_rise = tck & ~tck_q_r;
    tck_fall = ~tck & tck_q_r;
    tap_nxt = tap_r;
    if (tck_rise) begin
      case (tap_r) // [R14]
        pfs_tap_reset: tap_nxt = tms ? pfs_tap_reset : pfs_tap_idle;
        pfs_tap_idle: tap_nxt = tms ? pfs_tap_sel_dr : pfs_tap_idle;
        pfs_tap_sel_dr: tap_nxt = tms ? pfs_tap_sel_ir : pfs_tap_cap_dr;
        pfs_tap_cap_dr: tap_nxt = tms ? pfs_tap_exit1_dr : pfs_tap_shift_dr;
        pfs_tap_shift_dr: tap_nxt = tms ? pfs_tap_exit1_dr : pfs_tap_shift_dr;
        pfs_tap_exit1_dr: tap_nxt = tms ? pfs_tap_upd_dr : pfs_tap_pause_dr;
        pfs_tap_pause_dr: tap_nxt = tms ? pfs_tap_exit2_dr : pfs_tap_pause_dr;
        pfs_tap_exit2_dr: tap_nxt = tms ? pfs_tap_upd_dr : pfs_tap_shift_dr;
        pfs_tap_upd_dr: tap_nxt = tms ? pfs_tap_sel_dr : pfs_tap_idle;
        pfs_tap_sel_ir: tap_nxt = tms ? pfs_tap_reset : pfs_tap_cap_ir;
        pfs_tap_cap_ir: tap_nxt = tms ? pfs_tap_exit1_ir : pfs_tap_shift_ir;
        pfs_tap_shift_ir: tap_nxt = tms ? pfs_tap_exit1_ir : pfs_tap_shift_ir;
        pfs_tap_exit1_ir: tap_nxt = tms ? pfs_tap_upd_ir : pfs_tap_pause_ir;
        pfs_tap_pause_ir: tap_nxt = tms ? pfs_tap_exit2_ir : pfs_tap_pause_ir;
        pfs_tap_exit2_ir: tap_nxt = tms ? pfs_tap_upd_ir : pfs_tap_shift_ir;
        pfs_tap_upd_ir: tap_nxt = tms ? pfs_tap_sel_dr : pfs_tap_idle;
        default: tap_nxt = pfs_tap_reset;
      endcase
    end
    tdi_bit_nxt = tdi_bit;
    tdi_strobe_nxt = 1'b0;
    if (tck_rise && is_shift(tap_r)) begin
      tdi_bit_nxt = tdi; // [R15]
      tdi_strobe_nxt = 1'b1;
    end
    tdo_nxt = tdo_pad;
    if (tck_fall) begin
      tdo_nxt.o = tdo_src; // [R17]
      tdo_nxt.oe = is_shift(tap_r); // [R17]
      tdo_nxt.pu = ~is_shift(tap_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tck_q_r <= 1'b0;
      tap_r <= pfs_tap_reset;
      tdi_bit <= 1'b0;
      tdi_strobe <= 1'b0;
      tdo_pad <= '{o: 1'b0, oe: 1'b0, pu: 1'b1};
    end else begin
      tck_q_r <= tck_q_nxt;
      tap_r <= tap_nxt;
      tdi_bit <= tdi_bit_nxt;
      tdi_strobe <= tdi_strobe_nxt;
      tdo_pad <= tdo_nxt;
    end
  end

  assign tap_state = tap_r;

endmodule

// *** pfs_cfg.svh ***
// Bit positions, reset values and widths for the pad function select block
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
`define PFS_W 16
`define PFS_TAP_W 4
// Port D lines
`define PFS_BIT_D_LINE_ONE 1
`define PFS_BIT_D_LINE_SIX 6
`define PFS_BIT_D_LINE_SEVEN 7
// Port E lines
`define PFS_BIT_E_LINE_ZERO 0
`define PFS_BIT_E_LINE_ONE 1
// Global select bit for port D line one
`define PFS_BIT_GPS_D_LINE_ONE 5
// Test-port bit in the pull-up disable register
`define PFS_BIT_PUD_TEST 0
// Reset values
`define PFS_RST_PER_D 16'h00c0
`define PFS_RST_PER_E 16'h0003
`define PFS_RST_GPS 16'h0000
`define PFS_RST_PUR 16'hffff
`define PFS_RST_PUDR 16'h0000
`define PFS_RST_DIR 16'h0000
`define PFS_RST_DATA 16'h0000
`define PFS_ZERO 16'h0000
`endif

// *** pfs_pkg.sv ***
// Types shared by the pad function select block
`include "pfs_cfg.svh"
package pfs_pkg;
  typedef enum logic [3:0] {
    pfs_port_d_peripheral_enable,
    pfs_port_e_peripheral_enable,
    pfs_global_peripheral_select,
    pfs_port_d_pullup_enable,
    pfs_port_e_pullup_enable,
    pfs_pullup_disable_register,
    pfs_port_d_direction,
    pfs_port_e_direction,
    pfs_port_d_data,
    pfs_port_e_data,
    pfs_port_d_pins,
    pfs_port_e_pins
  } pfs_reg_t;

  typedef enum logic [`PFS_TAP_W-1:0] {
    pfs_tap_reset, pfs_tap_idle,
    pfs_tap_sel_dr, pfs_tap_cap_dr, pfs_tap_shift_dr, pfs_tap_exit1_dr,
    pfs_tap_pause_dr, pfs_tap_exit2_dr, pfs_tap_upd_dr,
    pfs_tap_sel_ir, pfs_tap_cap_ir, pfs_tap_shift_ir, pfs_tap_exit1_ir,
    pfs_tap_pause_ir, pfs_tap_exit2_ir, pfs_tap_upd_ir
  } pfs_tap_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } pfs_pad_t;

  typedef struct packed {
    logic we;
    pfs_reg_t sel;
    logic [`PFS_W-1:0] data;
  } pfs_wr_t;
endpackage

// *** pfs_pad_mux_chk.sv ***
// Assertion checker for the pad function select block
`timescale 1ns/1ps
module pfs_pad_mux_chk
  import pfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pfs_wr_t wr,
  input wire pfs_pad_t d1_pad,
  input wire pfs_pad_t e0_pad,
  input wire pfs_pad_t e1_pad,
  input wire pfs_pad_t d6_pad,
  input wire pfs_pad_t d7_pad,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tck_pd,
  input wire logic tms_pu,
  input wire logic tdi_pu,
  input wire pfs_pad_t tdo_pad,
  input wire logic tdi_bit,
  input wire logic tdi_strobe,
  input wire pfs_tap_t tap_state
);
  // ---------------------------------
  // Sequences
  // ---------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence tck_rise_s;
    !tck ##1 tck;
  endsequence
  sequence in_shift_s;
    tap_state inside {pfs_tap_shift_dr, pfs_tap_shift_ir};
  endsequence
  // ---------------------------------
  // Assertions
  // ---------------------------------
  AST_D1_RESET: assert property ($rose(rst_n) |=> d1_pad == 3'h1)
    else $error("pad 49 left reset not as pulled-up input");
  AST_TX_RESET: assert property ($rose(rst_n) |->
    e0_pad == 3'h1 && d6_pad == 3'h1 ##1 e0_pad.oe && d6_pad.oe)
    else $error("transmit pad reset state wrong");
  AST_RX_RESET: assert property ($rose(rst_n) |=>
    e1_pad == 3'h5 && d7_pad == 3'h5)
    else $error("receive pad reset state wrong");
  AST_TCK_PD: assert property (tck_pd)
    else $error("test clock pull-down off");
  AST_PUD: assert property (wr.we && wr.sel == pfs_pullup_disable_register
    |=> tms_pu == !$past(wr.data[0]) && tdi_pu == tms_pu)
    else $error("test pull-ups ignore disable bit");
  AST_TAP_EDGE: assert property ($changed(tap_state) |->
    $past(tck) && !$past(tck, 2))
    else $error("tap state moved without test clock rise");
  AST_TDI_SAMPLE: assert property (tck_rise_s ##0 in_shift_s |=>
    tdi_strobe && tdi_bit == $past(tdi))
    else $error("test data not sampled on rise");
  AST_TDO_EN: assert property ($rose(tdo_pad.oe) |-> in_shift_s)
    else $error("test data out driven outside shift");
  AST_TDO_FALL: assert property ($changed(tdo_pad.o) ||
    $changed(tdo_pad.oe) |-> $past(tck, 2) && !$past(tck))
    else $error("test data out moved off falling edge");
endmodule

bind pfs_pad_mux pfs_pad_mux_chk u_chk (.clk, .rst_n, .wr, .d1_pad,
  .e0_pad, .e1_pad, .d6_pad, .d7_pad, .tck, .tdi, .tck_pd, .tms_pu,
  .tdi_pu, .tdo_pad, .tdi_bit, .tdi_strobe, .tap_state);

// *** pfs_board.sv ***
// Board model: pad lines, external drivers, pulls and test clock line
`timescale 1ns/1ps
module pfs_board
  import pfs_pkg::*;
(
  input wire logic clk,
  input wire pfs_pad_t d1_pad,
  input wire pfs_pad_t e0_pad,
  input wire pfs_pad_t e1_pad,
  input wire pfs_pad_t d6_pad,
  input wire pfs_pad_t d7_pad,
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_v,
  input wire logic tck_en,
  input wire logic tck_v,
  input wire logic tck_pd,
  output logic [4:0] lvl,
  output logic tck
);
  pfs_pad_t [4:0] p;
  logic tog_r = 1'b0;
  // Unpulled float toggles so a stale level never passes
  always_ff @(posedge clk) tog_r <= ~tog_r;
  assign p = {d7_pad, d6_pad, e1_pad, e0_pad, d1_pad};
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (p[i].oe)
        lvl[i] = p[i].o;
      else if (ext_en[i])
        lvl[i] = ext_v[i];
      else
        lvl[i] = p[i].pu | tog_r;
    end
  end
  // Probe clock stands low between frames
  assign tck = tck_en ? tck_v : (tck_pd ? 1'b0 : tog_r);
endmodule

// *** pfs_pad_mux_tb.sv ***
// Self-checking testbench for the pad function select block
`timescale 1ns/1ps
module pfs_pad_mux_tb;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pfs_wr_t wr = '0;
  pfs_reg_t rd_sel = pfs_port_d_peripheral_enable;
  logic memory_chip_select_three_n = 1'b1;
  logic ext_bus_active = 1'b0;
  logic idle_bus_drive_control = 1'b0;
  logic serial_zero_transmit = 1'b1;
  logic serial_one_transmit = 1'b0;
  logic tms = 1'b1, tdi = 1'b0, tdo_src = 1'b1, tck_en = 1'b0, tck_v = 1'b0;
  logic [4:0] ext_en = 5'h00, ext_v = 5'h00, lvl;
  logic tck, tck_pd, tms_pu, tdi_pu, tdi_bit, tdi_strobe;
  logic can_receive_input, serial_zero_receive, serial_one_receive;
  logic [15:0] rd_data;
  pfs_pad_t d1_pad, e0_pad, e1_pad, d6_pad, d7_pad, tdo_pad;
  pfs_tap_t tap_state;
  int failures = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  pfs_pad_mux DUT (.clk, .rst_n, .wr, .rd_sel, .rd_data, .d1_in(lvl[0]),
    .d1_pad, .e0_in(lvl[1]), .e0_pad, .e1_in(lvl[2]), .e1_pad,
    .d6_in(lvl[3]), .d6_pad, .d7_in(lvl[4]), .d7_pad,
    .memory_chip_select_three_n, .ext_bus_active, .idle_bus_drive_control,
    .can_receive_input, .serial_zero_transmit, .serial_zero_receive,
    .serial_one_transmit, .serial_one_receive, .tck, .tms, .tdi, .tck_pd,
    .tms_pu, .tdi_pu, .tdo_src, .tdo_pad, .tdi_bit, .tdi_strobe, .tap_state);
  pfs_board u_board (.clk, .d1_pad, .e0_pad, .e1_pad, .d6_pad, .d7_pad,
    .ext_en, .ext_v, .tck_en, .tck_v, .tck_pd, .lvl, .tck);
  // ---------------------------------
  // Shared tasks
  // ---------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input pfs_reg_t s, input logic [15:0] d);
    wr = '{1'b1, s, d};
    cyc(1);
    wr.we = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input pfs_reg_t s, input logic [15:0] exp);
    rd_sel = s;
    cyc(2);
    chk(rd_data, exp);
  endtask
  // Tms and tdi set a cycle ahead and held across both phases
  task automatic tclk(input logic m, input logic d);
    tms = m;
    tdi = d;
    tck_en = 1'b1;
    cyc(1);
    tck_v = 1'b1;
    cyc(3);
    tck_v = 1'b0;
    cyc(3);
  endtask
  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic t_defaults;
    chk(16'(d1_pad), 16'h0001);
    chk(16'({e0_pad, d6_pad}), 16'h0032);
    chk(16'({e1_pad, d7_pad}), 16'h002d);
    ext_en = 5'h14;
    cyc(3);
    chk(16'({serial_zero_receive, serial_one_receive}), 16'h0000);
    ext_en = 5'h00;
    chk(16'({tck_pd, tck}), 16'h0002);
    rd(pfs_port_d_peripheral_enable, 16'h00c0);
    rd(pfs_port_d_pullup_enable, 16'hffff);
    rd(pfs_port_d_pins, 16'h0082);
    rd(pfs_port_e_pins, 16'h0003);
    $display("t_defaults done");
  endtask
  task automatic t_gpio;
    wreg(pfs_port_d_peripheral_enable, 16'h0000);
    wreg(pfs_global_peripheral_select, 16'h0020);
    wreg(pfs_port_d_direction, 16'h0002);
    wreg(pfs_port_d_data, 16'h0002);
    chk(16'(d1_pad), 16'h0006);
    wreg(pfs_port_d_direction, 16'h0042);
    chk(16'({d1_pad, d6_pad, d7_pad}), 16'h0191);
    wreg(pfs_port_d_direction, 16'h0000);
    $display("t_gpio done");
  endtask
  task automatic t_pullup;
    wreg(pfs_port_e_peripheral_enable, 16'h0000);
    wreg(pfs_port_d_pullup_enable, 16'hff3d);
    chk(16'({d1_pad, d6_pad, d7_pad}), 16'h0100);
    wreg(pfs_port_d_pullup_enable, 16'hffbf);
    chk(16'({d1_pad, d6_pad, d7_pad}), 16'h0141);
    wreg(pfs_port_e_pullup_enable, 16'hfffe);
    chk(16'({e0_pad, e1_pad}), 16'h0001);
    wreg(pfs_port_e_pullup_enable, 16'hfffd);
    chk(16'({e0_pad, e1_pad}), 16'h0008);
    wreg(pfs_port_d_pullup_enable, 16'hffff);
    wreg(pfs_port_e_pullup_enable, 16'hffff);
    wreg(pfs_port_e_peripheral_enable, 16'h0003);
    $display("t_pullup done");
  endtask
  task automatic t_chip_select;
    wreg(pfs_global_peripheral_select, 16'h0000);
    wreg(pfs_port_d_peripheral_enable, 16'h00c2);
    memory_chip_select_three_n = 1'b0;
    cyc(2);
    chk(16'(d1_pad), 16'h0001);
    ext_bus_active = 1'b1;
    cyc(2);
    chk(16'(d1_pad), 16'h0002);
    ext_bus_active = 1'b0;
    memory_chip_select_three_n = 1'b1;
    idle_bus_drive_control = 1'b1;
    cyc(2);
    chk(16'(d1_pad), 16'h0006);
    $display("t_chip_select done");
  endtask
  task automatic t_can;
    wreg(pfs_global_peripheral_select, 16'h0020);
    chk(16'(d1_pad), 16'h0005);
    ext_en = 5'h01;
    cyc(3);
    chk(16'(can_receive_input), 16'h0000);
    ext_en = 5'h00;
    cyc(3);
    chk(16'(can_receive_input), 16'h0001);
    wreg(pfs_port_d_peripheral_enable, 16'h00c0);
    $display("t_can done");
  endtask
  task automatic t_test_port;
    wreg(pfs_pullup_disable_register, 16'h0001);
    chk(16'({tms_pu, tdi_pu}), 16'h0000);
    wreg(pfs_pullup_disable_register, 16'h0000);
    chk(16'({tms_pu, tdi_pu}), 16'h0003);
    tclk(1'b0, 1'b0);
    tclk(1'b1, 1'b0);
    tclk(1'b0, 1'b0);
    tclk(1'b0, 1'b0);
    chk(16'(tap_state), 16'(pfs_tap_shift_dr));
    chk(16'(tdo_pad), 16'h0006);
    tdo_src = 1'b0;
    tclk(1'b0, 1'b1);
    chk(16'(tdi_bit), 16'h0001);
    chk(16'(tdo_pad), 16'h0002);
    tclk(1'b1, 1'b0);
    chk(16'({tdi_bit, tdo_pad}), 16'h0001);
    repeat (5) tclk(1'b1, 1'b0);
    chk(16'(tap_state), 16'(pfs_tap_reset));
    tck_en = 1'b0;
    $display("t_test_port done");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(2);
    t_defaults;
    t_gpio;
    t_pullup;
    t_chip_select;
    t_can;
    t_test_port;
    final_report;
  end
  // Tests need about 145 cycles
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule
